// file: bench/ext_clock_src.sv
// External reference clock that drives the sync pin.
// Assumes a pull-down holds the pin low while the source is stopped.
`timescale 1ns/1ps

module ext_clock_src
#(
	parameter int HALF_NS = 500
)
(
	input wire logic run_i, // Source running.
	output logic clk_o // Pin level.
);
	// Exact nominal rate, so inside the tolerance window.
	always
	begin
		clk_o = 1'b0;
		while (run_i)
		begin
			#HALF_NS clk_o = ~clk_o;
		end
		@(run_i);
	end
endmodule

// file: bench/lmcs_props.sv
// Port checker for the load-measurement and clock-sync control block.
// Assumes the bind at the foot reaches every instance of that block.
`timescale 1ns/1ps
`include "lmcs_consts.svh"

module lmcs_props
(
	input wire logic mclk_i, // Clock.
	input wire logic rst_b_i, // Reset.
	input wire logic psel_i, // Select.
	input wire logic penable_i, // Enable.
	input wire logic pwrite_i, // Write.
	input wire logic [7:0] paddr_i, // Address.
	input wire logic [31:0] pwdata_i, // Write data.
	input wire logic sync_pin_i, // Sync pin.
	input wire logic sync_pin_oe_o, // Sync drive.
	input wire logic [1:0] pwm_mode_o, // Modes.
	input wire logic meas_target_o, // Target.
	input wire logic meas_active_o, // Busy.
	input wire logic pll_enable_o, // Detector on.
	input wire logic ext_clk_sel_o, // External clock.
	input wire logic dither_en_o // Dither.
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	logic prev_q;
	logic [6:0] still_q;
	logic [10:0] run_q;
	wire wr_sel = psel_i && penable_i && pwrite_i && paddr_i == `A_MEAS_SEL;

	// Counts cycles with no edge on the raw sync pin.
	always_ff @(posedge mclk_i)
	begin
		prev_q <= sync_pin_i;
		if (!rst_b_i || sync_pin_i != prev_q)
			still_q <= 7'h00;
		else if (still_q != 7'h7F)
			still_q <= still_q + 7'h01;
	end

	// Counts cycles of the current measurement; a select write restarts it.
	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i || !meas_active_o || wr_sel)
			run_q <= 11'h000;
		else if (run_q != 11'h7FF)
			run_q <= run_q + 11'h001;
	end

	meas_start_a: assert property (wr_sel |=> meas_active_o)
		else $error("Measurement did not start.");
	meas_target_a: assert property (wr_sel |=> meas_target_o == $past(pwdata_i[0]))
		else $error("Wrong converter measured.");
	forced_pwm_a: assert property (meas_active_o |-> pwm_mode_o[meas_target_o])
		else $error("Measured converter not in PWM.");
	meas_bound_a: assert property (meas_active_o |-> run_q < 11'(`MEAS_MAX_US * `MCLK_MHZ))
		else $error("Measurement too long.");
	sync_dither_a: assert property (pll_enable_o |=> !dither_en_o)
		else $error("Dither on while sync enabled.");
	dither_gate_a: assert property (ext_clk_sel_o ##1 ext_clk_sel_o |-> !dither_en_o)
		else $error("Dither on external clock.");
	pll_off_a: assert property (!pll_enable_o ##1 !pll_enable_o |-> !ext_clk_sel_o)
		else $error("External clock with detector off.");
	aux2_pin_a: assert property (pll_enable_o ##1 pll_enable_o |-> !sync_pin_oe_o)
		else $error("Sync pin driven while syncing.");
	clock_loss_a: assert property (still_q == 7'h40 |-> !ext_clk_sel_o)
		else $error("Lost clock still selected.");
endmodule

bind load_meas_clock_sync_ctrl lmcs_props i_lmcs_props (.mclk_i, .rst_b_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .sync_pin_i, .sync_pin_oe_o,
	.pwm_mode_o, .meas_target_o, .meas_active_o, .pll_enable_o, .ext_clk_sel_o,
	.dither_en_o);

// file: bench/load_meas_clock_sync_ctrl_test.sv
// Self-checking bench for the load-measurement and clock-sync block.
// Assumes the checker is bound and the design files are compiled first.
`timescale 1ns/1ps
`include "lmcs_consts.svh"

module load_meas_clock_sync_ctrl_test;
	logic mclk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic [8:0] meas_code_i = 9'h000;
	logic [1:0] load_high_i = 2'h0, pwm_mode_o;
	logic startup_done_i = 1'b0, conv_enable_i = 1'b0, run = 1'b0, err, src_clk;
	logic pready_o, pslverr_o, sync_pin_o, sync_pin_oe_o, aux1_o, aux1_oe_o;
	logic meas_target_o, meas_active_o, pll_enable_o, ext_clk_sel_o, dither_en_o, irq_o;
	int error_cnt = 0, comparisons = 0, cyc = 0, n;
	wire sync_pin_i = sync_pin_oe_o ? sync_pin_o : src_clk;
	wire [1:0] obs = {irq_o, ext_clk_sel_o};

	load_meas_clock_sync_ctrl #(.SWITCH_DELAY_CYC(20)) i_load_meas_clock_sync_ctrl (.mclk_i,
		.rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
		.pslverr_o, .meas_code_i, .load_high_i, .startup_done_i, .conv_enable_i,
		.sync_pin_i, .sync_pin_o, .sync_pin_oe_o, .aux1_o, .aux1_oe_o, .pwm_mode_o,
		.meas_target_o, .meas_active_o, .pll_enable_o, .ext_clk_sel_o, .dither_en_o, .irq_o);
	ext_clock_src i_ext_clock_src (.run_i(run), .clk_o(src_clk));

	always #20 mclk_i = ~mclk_i;

	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			error_cnt++;
			conclude();
		end
	end

	task conclude();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge mclk_i);
		end
		while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask

	task wt(input int b, input logic v, input int lim);
		n = 0;
		while (obs[b] !== v && n < lim)
		begin
			@(negedge mclk_i);
			n++;
		end
	endtask

	task meas(input logic sel, input logic [8:0] code);
		@(posedge mclk_i);
		meas_code_i <= code;
		wr(`A_MEAS_SEL, {31'h0, sel});
		@(negedge mclk_i);
		chk(meas_active_o, 1'b1);
		chk(pwm_mode_o[sel], 1'b1);
		chk(meas_target_o, sel);
		n = 0;
		while (meas_active_o === 1'b1 && n < 1300)
		begin
			@(negedge mclk_i);
			n++;
		end
		chk(n <= 1250, 1'b1);
		rdc(`A_RESULT_LO, {24'h0, code[7:0]});
		rdc(`A_RESULT_HI, {31'h0, code[8]});
	endtask

	task pulse(input logic conv);
		@(posedge mclk_i);
		startup_done_i <= !conv;
		conv_enable_i <= conv;
		@(posedge mclk_i);
		startup_done_i <= 1'b0;
		conv_enable_i <= 1'b0;
		repeat (2) @(negedge mclk_i);
	endtask

	initial
	begin
		repeat (20) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		rdc(`A_CLOCK_CTRL, 32'h0);
		apb(8'h20, 1'b0, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		wr(`A_MODE_CTRL, 32'h1);
		repeat (2) @(negedge mclk_i);
		chk(pwm_mode_o, 2'b01);
		meas(1'b0, 9'h1FF);
		chk(irq_o, 1'b1);
		rdc(`A_EVENT_FLAGS, 32'h1);
		wr(`A_EVENT_FLAGS, 32'h1);
		rdc(`A_EVENT_FLAGS, 32'h0);
		rdc(`A_RESULT_LO, 32'hFF);
		wr(`A_EVENT_MASK, 32'h1);
		meas(1'b1, 9'h0AB);
		rdc(`A_EVENT_FLAGS, 32'h1);
		chk(irq_o, 1'b0);
		wr(`A_EVENT_FLAGS, 32'h1);
		load_high_i <= 2'b10;
		wr(`A_MODE_CTRL, 32'h0);
		repeat (4) @(negedge mclk_i);
		chk(pwm_mode_o, 2'b10);
		wr(`A_CLOCK_CTRL, 32'h40);
		repeat (2) @(negedge mclk_i);
		chk(dither_en_o, 1'b1);
		// A 3 MHz setting against a 1 MHz source must never be accepted.
		wr(`A_CLOCK_CTRL, 32'h47);
		run <= 1'b1;
		repeat (1500) @(negedge mclk_i);
		rdc(`A_EVENT_FLAGS, 32'h0);
		chk(dither_en_o, 1'b0);
		wr(`A_CLOCK_CTRL, 32'h43);
		wt(1, 1'b1, 3000);
		rdc(`A_EVENT_FLAGS, 32'h2);
		wt(0, 1'b1, 100);
		chk(n > 10 && n < 30, 1'b1);
		chk(dither_en_o, 1'b0);
		rdc(`A_STATUS, 32'h16);
		wr(`A_EVENT_FLAGS, 32'h2);
		run <= 1'b0;
		wt(0, 1'b0, 80);
		chk(ext_clk_sel_o, 1'b0);
		rdc(`A_EVENT_FLAGS, 32'h2);
		wr(`A_EVENT_FLAGS, 32'h2);
		pulse(1'b0);
		rdc(`A_EVENT_FLAGS, 32'h2);
		wr(`A_EVENT_FLAGS, 32'h2);
		wr(`A_EVENT_MASK, 32'h3);
		pulse(1'b1);
		rdc(`A_EVENT_FLAGS, 32'h2);
		chk(irq_o, 1'b0);
		wr(`A_MODE_CTRL, 32'h6C);
		repeat (2) @(negedge mclk_i);
		chk({aux1_oe_o, sync_pin_o, sync_pin_oe_o, pll_enable_o}, 4'b0110);
		wr(`A_MODE_CTRL, 32'h0C);
		repeat (2) @(negedge mclk_i);
		chk({aux1_o, aux1_oe_o, sync_pin_o, sync_pin_oe_o}, 4'b0101);
		conclude();
	end
endmodule

// file: design/lmcs_consts.svh
// Constants for the load-measurement and clock-sync control block.
// Assumes a 25 MHz core clock and an APB slave with byte addresses.
`ifndef LMCS_CONSTS_SVH
`define LMCS_CONSTS_SVH

`define MCLK_MHZ 25
`define MCLK_NS 40

// Register byte addresses.
`define A_MEAS_SEL 8'h00
`define A_RESULT_LO 8'h04
`define A_RESULT_HI 8'h08
`define A_EVENT_FLAGS 8'h0C
`define A_EVENT_MASK 8'h10
`define A_CLOCK_CTRL 8'h14
`define A_MODE_CTRL 8'h18
`define A_STATUS 8'h1C

// Field positions.
`define B_MEAS_TARGET 0
`define B_EV_MEAS 0
`define B_EV_CLK 1
`define B_SYNC_EN 0
`define F_NOM_LO 1
`define F_NOM_HI 5
`define B_DITHER 6
`define F_FPWM_LO 0
`define F_FPWM_HI 1
`define B_AUX2_SEL 2
`define F_AUX_OD_LO 3
`define F_AUX_OD_HI 4
`define F_AUX_VAL_LO 5
`define F_AUX_VAL_HI 6
`define F_RES_LOW_HI 7
`define B_RES_MSB 8
`define B_RES_HI 0
`define B_ST_BUSY 0
`define B_ST_VALID 1
`define B_ST_EXT 2
`define F_ST_PWM_LO 3
`define F_ST_PWM_HI 4

// Widths.
`define RESULT_W 9
`define NOM_W 5
`define MEAS_CNT_W 11
`define SW_CNT_W 16
`define EDGE_W 9
`define WIN_W 8
`define GAP_W 6

// Timing, in the printed units, and derived cycle counts.
`define MEAS_PFM_US 45
`define MEAS_PWM_US 4
`define MEAS_MAX_US 50
`define MEAS_PFM_CYC (`MEAS_PFM_US * `MCLK_MHZ)
`define MEAS_PWM_CYC (`MEAS_PWM_US * `MCLK_MHZ)
`define EXT_SWITCH_US 600
`define EXT_SWITCH_CYC (`EXT_SWITCH_US * `MCLK_MHZ)
`define WIN_US 10
`define WIN_CYC (`WIN_US * `MCLK_MHZ)
`define MISS_NS 1800
`define MISS_CYC (`MISS_NS / `MCLK_NS)
`define TOL_PCT 10
`define PCT_FULL 100

// One result count is 20 mA; all ones reads as 10.22 A.
`define RESULT_LSB_MA 20

`endif

// file: design/lmcs_pkg.sv
// Types for the load-measurement and clock-sync control block.
// Assumes lmcs_consts.svh on the include path.
`include "lmcs_consts.svh"

package lmcs_pkg;

	typedef enum logic [1:0] {
		CLK_INT = 2'h0,
		CLK_WAIT = 2'h1,
		CLK_EXT = 2'h3
	} clk_state_t;

	typedef enum logic {
		MEAS_IDLE = 1'h0,
		MEAS_RUN = 1'h1
	} meas_state_t;

	typedef struct packed {
		meas_state_t meas_st;
		logic meas_target;
		logic [`MEAS_CNT_W-1:0] meas_cnt;
		logic [`RESULT_W-1:0] result;
		logic meas_flag;
		logic clk_flag;
		logic meas_mask;
		logic clk_mask;
		logic sync_en;
		logic [`NOM_W-1:0] nom_freq;
		logic dither_en;
		logic [1:0] fpwm;
		logic aux2_sel;
		logic [1:0] aux_od;
		logic [1:0] aux_val;
		clk_state_t clk_st;
		logic [`SW_CNT_W-1:0] sw_cnt;
		logic [1:0] load_s1;
		logic [1:0] load_s2;
		logic [`RESULT_W-1:0] code_s1;
		logic [`RESULT_W-1:0] code_s2;
		logic [31:0] prdata;
		logic slverr;
		logic [1:0] pwm;
		logic dither;
		logic irq;
		logic aux1;
		logic aux1_oe;
		logic pin;
		logic pin_oe;
	} ctrl_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic [`WIN_W-1:0] win_cnt;
		logic [`EDGE_W-1:0] edge_cnt;
		logic [`GAP_W-1:0] gap_cnt;
		logic good;
		logic valid;
	} mon_state_t;

endpackage

// file: design/load_meas_clock_sync_ctrl.sv
// Load-current measurement sequencer, sync clock control and output muxing.
// Assumes an APB master on mclk_i and analog front ends outside this block.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module load_meas_clock_sync_ctrl
	import lmcs_pkg::*;
#(
	parameter int unsigned SWITCH_DELAY_CYC = `EXT_SWITCH_CYC // Clock change delay.
)
(
	input wire logic mclk_i, // Core clock, 25 MHz.
	input wire logic rst_b_i, // Synchronous reset, active low.
	input wire logic psel_i, // APB select.
	input wire logic penable_i, // APB enable.
	input wire logic pwrite_i, // APB direction, high for write.
	input wire logic [7:0] paddr_i, // APB byte address.
	input wire logic [31:0] pwdata_i, // APB write data.
	output logic [31:0] prdata_o, // APB read data.
	output logic pready_o, // APB ready.
	output logic pslverr_o, // APB error for unmapped address.
	input wire logic [`RESULT_W-1:0] meas_code_i, // Current code from the sensor.
	input wire logic [1:0] load_high_i, // Per converter load above PWM level.
	input wire logic startup_done_i, // Pulse at start-up into standby.
	input wire logic conv_enable_i, // Pulse at standby to active.
	input wire logic sync_pin_i, // Sync pin level.
	output logic sync_pin_o, // Sync pin drive value.
	output logic sync_pin_oe_o, // Sync pin drive enable.
	output logic aux1_o, // First aux output drive value.
	output logic aux1_oe_o, // First aux output drive enable.
	output logic [1:0] pwm_mode_o, // Per converter PWM when high, PFM when low.
	output logic meas_target_o, // Converter under measurement.
	output logic meas_active_o, // Measurement running.
	output logic pll_enable_o, // Detector and PLL powered.
	output logic ext_clk_sel_o, // Converters use external clock.
	output logic dither_en_o, // Spread-spectrum for both converters.
	output logic irq_o // Unmasked event pending, active high.
);

	ctrl_state_t q;
	ctrl_state_t d;
	logic ext_valid;
	logic mon_en;
	logic wr;
	logic setup;
	logic meas_start;
	logic meas_end;
	logic clk_set;
	logic [1:0] ev_clr;
	logic [1:0] meas_force;
	logic [1:0] aux_drive;

	// Hardware set wins over a software clear in the same cycle.
	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction

	// Open-drain drives only a low; push-pull always drives.
	function automatic logic pin_enable(input logic od, input logic val);
		return od ? ~val : 1'b1;
	endfunction

	sync_clock_monitor i_sync_clock_monitor (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.enable_i(mon_en),
		.pin_i(sync_pin_i),
		.nominal_i(q.nom_freq),
		.valid_o(ext_valid)
	);

	always_comb
	begin
		d = q;
		clk_set = 1'b0;
		meas_end = 1'b0;
		ev_clr = 2'h0;

		// Load flags and the sensor code pass two flops first.
		d.load_s1 = load_high_i;
		d.load_s2 = q.load_s1;
		d.code_s1 = meas_code_i;
		d.code_s2 = q.code_s1;

		wr = psel_i & penable_i & pwrite_i;
		setup = psel_i & ~penable_i;
		meas_start = wr && (paddr_i == `A_MEAS_SEL);

		// Detector runs only when sync is wanted and the pin is an input.
		mon_en = q.sync_en & ~q.aux2_sel;

		// Register writes, taken at the access edge.
		if (wr)
		begin
			unique case (paddr_i)
				`A_MEAS_SEL:
				begin
					d.meas_target = pwdata_i[`B_MEAS_TARGET];
				end
				`A_EVENT_FLAGS:
				begin
					ev_clr[0] = pwdata_i[`B_EV_MEAS];
					ev_clr[1] = pwdata_i[`B_EV_CLK];
				end
				`A_EVENT_MASK:
				begin
					d.meas_mask = pwdata_i[`B_EV_MEAS];
					d.clk_mask = pwdata_i[`B_EV_CLK];
				end
				`A_CLOCK_CTRL:
				begin
					d.sync_en = pwdata_i[`B_SYNC_EN];
					d.nom_freq = pwdata_i[`F_NOM_HI:`F_NOM_LO];
					d.dither_en = pwdata_i[`B_DITHER];
				end
				`A_MODE_CTRL:
				begin
					d.fpwm = pwdata_i[`F_FPWM_HI:`F_FPWM_LO];
					d.aux2_sel = pwdata_i[`B_AUX2_SEL];
					d.aux_od = pwdata_i[`F_AUX_OD_HI:`F_AUX_OD_LO];
					d.aux_val = pwdata_i[`F_AUX_VAL_HI:`F_AUX_VAL_LO];
				end
				default:
				begin
					d.meas_target = q.meas_target;
				end
			endcase
		end

		// Measurement sequencer; a new write restarts a running one.
		unique case (q.meas_st)
			MEAS_IDLE:
			begin
				if (meas_start)
				begin
					d.meas_st = MEAS_RUN;
				end
			end
			MEAS_RUN:
			begin
				if (meas_start)
				begin
					d.meas_st = MEAS_RUN;
				end
				else if (q.meas_cnt == '0)
				begin
					d.meas_st = MEAS_IDLE;
					meas_end = 1'b1;
				end
				else
				begin
					d.meas_cnt = q.meas_cnt - 1'b1;
				end
			end
		endcase
		if (meas_start)
		begin
			// A converter in PFM needs the long settle into PWM.
			if (q.pwm[pwdata_i[`B_MEAS_TARGET]])
			begin
				d.meas_cnt = `MEAS_CNT_W'(`MEAS_PWM_CYC - 1);
			end
			else
			begin
				d.meas_cnt = `MEAS_CNT_W'(`MEAS_PFM_CYC - 1);
			end
		end
		if (meas_end)
		begin
			// Code is kept raw; each count weighs 20 mA.
			d.result = q.code_s2;
		end

		// External clock selection.
		unique case (q.clk_st)
			CLK_INT:
			begin
				if (mon_en && ext_valid)
				begin
					d.clk_st = CLK_WAIT;
					d.sw_cnt = `SW_CNT_W'(SWITCH_DELAY_CYC - 1);
					clk_set = 1'b1;
				end
			end
			CLK_WAIT:
			begin
				if (!mon_en)
				begin
					d.clk_st = CLK_INT;
				end
				else if (!ext_valid)
				begin
					d.clk_st = CLK_INT;
					clk_set = 1'b1;
				end
				else if (q.sw_cnt == '0)
				begin
					d.clk_st = CLK_EXT;
				end
				else
				begin
					d.sw_cnt = q.sw_cnt - 1'b1;
				end
			end
			CLK_EXT:
			begin
				if (!mon_en)
				begin
					d.clk_st = CLK_INT;
				end
				else if (!ext_valid)
				begin
					// Switching continues on the RC clock.
					d.clk_st = CLK_INT;
					clk_set = 1'b1;
				end
			end
			default:
			begin
				d.clk_st = CLK_INT;
			end
		endcase
		if ((startup_done_i | conv_enable_i) && mon_en && !ext_valid)
		begin
			clk_set = 1'b1;
		end

		// Sticky events.
		d.meas_flag = flag_next(q.meas_flag, meas_end, ev_clr[0]);
		d.clk_flag = flag_next(q.clk_flag, clk_set, ev_clr[1]);
		d.irq = (d.meas_flag & ~d.meas_mask) | (d.clk_flag & ~d.clk_mask);

		// Converter modes.
		meas_force = 2'h0;
		if (d.meas_st == MEAS_RUN)
		begin
			meas_force[d.meas_target] = 1'b1;
		end
		d.pwm = meas_force | q.fpwm | q.load_s2;

		// One dither bit for both cores, off whenever sync is enabled.
		d.dither = q.dither_en & ~q.sync_en;

		// Aux outputs.
		aux_drive = q.aux_val;
		d.aux1 = aux_drive[0];
		d.aux1_oe = pin_enable(q.aux_od[0], aux_drive[0]);
		d.pin = q.aux2_sel & aux_drive[1];
		d.pin_oe = q.aux2_sel & pin_enable(q.aux_od[1], aux_drive[1]);

		// Read data is captured in the setup cycle.
		if (setup)
		begin
			d.slverr = 1'b0;
			d.prdata = '0;
			unique case (paddr_i)
				`A_MEAS_SEL:
				begin
					d.prdata[`B_MEAS_TARGET] = q.meas_target;
				end
				`A_RESULT_LO:
				begin
					d.prdata[`F_RES_LOW_HI:0] = q.result[`F_RES_LOW_HI:0];
				end
				`A_RESULT_HI:
				begin
					d.prdata[`B_RES_HI] = q.result[`B_RES_MSB];
				end
				`A_EVENT_FLAGS:
				begin
					d.prdata[`B_EV_MEAS] = q.meas_flag;
					d.prdata[`B_EV_CLK] = q.clk_flag;
				end
				`A_EVENT_MASK:
				begin
					d.prdata[`B_EV_MEAS] = q.meas_mask;
					d.prdata[`B_EV_CLK] = q.clk_mask;
				end
				`A_CLOCK_CTRL:
				begin
					d.prdata[`B_SYNC_EN] = q.sync_en;
					d.prdata[`F_NOM_HI:`F_NOM_LO] = q.nom_freq;
					d.prdata[`B_DITHER] = q.dither_en;
				end
				`A_MODE_CTRL:
				begin
					d.prdata[`F_FPWM_HI:`F_FPWM_LO] = q.fpwm;
					d.prdata[`B_AUX2_SEL] = q.aux2_sel;
					d.prdata[`F_AUX_OD_HI:`F_AUX_OD_LO] = q.aux_od;
					d.prdata[`F_AUX_VAL_HI:`F_AUX_VAL_LO] = q.aux_val;
				end
				`A_STATUS:
				begin
					d.prdata[`B_ST_BUSY] = (q.meas_st == MEAS_RUN);
					d.prdata[`B_ST_VALID] = ext_valid;
					d.prdata[`B_ST_EXT] = (q.clk_st == CLK_EXT);
					d.prdata[`F_ST_PWM_HI:`F_ST_PWM_LO] = q.pwm;
				end
				default:
				begin
					d.slverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	// Zero wait states: the access phase always completes.
	assign pready_o = psel_i & penable_i;
	assign pslverr_o = psel_i & penable_i & q.slverr;
	assign prdata_o = q.prdata;
	assign sync_pin_o = q.pin;
	assign sync_pin_oe_o = q.pin_oe;
	assign aux1_o = q.aux1;
	assign aux1_oe_o = q.aux1_oe;
	assign pwm_mode_o = q.pwm;
	assign meas_target_o = q.meas_target;
	assign meas_active_o = (q.meas_st == MEAS_RUN);
	assign pll_enable_o = q.sync_en & ~q.aux2_sel;
	assign ext_clk_sel_o = (q.clk_st == CLK_EXT);
	assign dither_en_o = q.dither;
	assign irq_o = q.irq;

endmodule

// file: design/sync_clock_monitor.sv
// External sync clock presence and frequency checker.
// Assumes the sync pin is asynchronous and well below half the core clock.
`timescale 1ns/1ps

module sync_clock_monitor
	import lmcs_pkg::*;
(
	input wire logic mclk_i, // Core clock.
	input wire logic rst_b_i, // Synchronous reset, active low.
	input wire logic enable_i, // Detector powered.
	input wire logic pin_i, // Raw sync pin level.
	input wire logic [`NOM_W-1:0] nominal_i, // Expected frequency in MHz.
	output logic valid_o // Clock present and inside the window.
);

	mon_state_t q;
	mon_state_t d;
	logic edge_seen;
	logic in_range;
	logic [`EDGE_W-1:0] expect_cnt;
	logic [`EDGE_W-1:0] tol_cnt;

	always_comb
	begin
		d = q;
		d.s1 = pin_i;
		d.s2 = q.s1;
		d.prev = q.s2;
		edge_seen = q.s2 & ~q.prev;
		expect_cnt = `EDGE_W'(nominal_i * `WIN_US);
		tol_cnt = `EDGE_W'((expect_cnt * `TOL_PCT) / `PCT_FULL);
		// Codes of zero never count as a valid clock.
		in_range = (nominal_i != '0) && (q.edge_cnt >= expect_cnt - tol_cnt)
			&& (q.edge_cnt <= expect_cnt + tol_cnt);
		if (!enable_i)
		begin
			d.win_cnt = `WIN_W'(`WIN_CYC - 1);
			d.edge_cnt = '0;
			d.gap_cnt = '0;
			d.good = 1'b0;
			d.valid = 1'b0;
		end
		else
		begin
			if (q.win_cnt == '0)
			begin
				d.win_cnt = `WIN_W'(`WIN_CYC - 1);
				d.edge_cnt = `EDGE_W'(edge_seen);
				// Two good windows in a row act as the debounce.
				d.good = in_range;
				d.valid = in_range & q.good;
			end
			else
			begin
				d.win_cnt = q.win_cnt - 1'b1;
				d.edge_cnt = q.edge_cnt + `EDGE_W'(edge_seen);
			end
			if (edge_seen)
			begin
				d.gap_cnt = '0;
			end
			else if (q.gap_cnt == `GAP_W'(`MISS_CYC - 1))
			begin
				d.good = 1'b0;
				d.valid = 1'b0;
			end
			else
			begin
				d.gap_cnt = q.gap_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign valid_o = q.valid;

endmodule
